// ### core/jtp_pkg.sv
// Shared constants, states and carrier types of the test access port
package jtp_pkg;
	localparam int unsigned IR_W = 4;                 // Instruction chain width
	localparam int unsigned ID_W = 32;                // Identification chain width
	localparam int unsigned TLR_TMS_CNT = 5;          // Consecutive TMS-high edges forcing reset
	localparam logic [2:0]  TMS_CNT_MAX = 3'h5;       // Saturation of the TMS-high counter
	localparam logic [3:0]  IR_CAPTURE = 4'h1;        // Fixed pattern loaded at IR capture
	// Instruction codes; the core debug group hands the data output to the core
	localparam logic [3:0]  IR_EXTEST = 4'h0;
	localparam logic [3:0]  IR_INTEST = 4'h1;
	localparam logic [3:0]  IR_SAMPLE = 4'h2;
	localparam logic [3:0]  IR_ABORT = 4'h8;
	localparam logic [3:0]  IR_DPACC = 4'hA;
	localparam logic [3:0]  IR_APACC = 4'hB;
	localparam logic [3:0]  IR_IDCODE = 4'hE;
	localparam logic [3:0]  IR_BYPASS = 4'hF;
	localparam logic [3:0]  IR_UNUSED = 4'h5;         // One code with no function, decodes as bypass
	localparam logic        PIN_TAP_RST = 1'h1;       // Shared pins start in test-port function

	typedef enum logic [3:0] {
		TLR     = 4'b0000,
		RTI     = 4'b0001,
		SEL_DR  = 4'b0010,
		CAP_DR  = 4'b0011,
		SH_DR   = 4'b0100,
		EX1_DR  = 4'b0101,
		PAU_DR  = 4'b0110,
		EX2_DR  = 4'b0111,
		UPD_DR  = 4'b1000,
		SEL_IR  = 4'b1001,
		CAP_IR  = 4'b1010,
		SH_IR   = 4'b1011,
		EX1_IR  = 4'b1100,
		PAU_IR  = 4'b1101,
		EX2_IR  = 4'b1110,
		UPD_IR  = 4'b1111
	} jtp_state_e;

	// Per-state chain actions
	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
	} jtp_ctl_s;
endpackage

// ### core/jtp_tap.sv
// Test access port controller with instruction, bypass, identification and boundary chains
`timescale 1ns/100ps
module jtp_tap #(
	parameter int unsigned  BSR_W = 8,                 // Boundary chain length
	parameter logic [31:0]  IDCODE_VAL = 32'h1234_5001 // Arbitrary identification value
) (
	input  wire logic             I_SYS_CLK,
	input  wire logic             I_NRST,
	input  wire logic             I_CE,
	input  wire logic             I_TCK,
	input  wire logic             I_TMS,
	input  wire logic             I_TDI,
	input  wire logic             I_CORE_TDO,
	input  wire logic [BSR_W-1:0] I_BSR_PINS,
	input  wire logic             I_GPIO_SEL,
	output logic                  O_TDO,
	output logic                  O_TDO_OE,
	output logic                  O_CORE_SEL,
	output logic [BSR_W-1:0]      O_BSR_UPD,
	output logic                  O_BSR_DRIVE,
	output logic                  O_TAP_RESET,
	output logic                  O_PIN_TAP
);
	jtp_pkg::jtp_state_e state_r;
	jtp_pkg::jtp_state_e state_nxt;
	jtp_pkg::jtp_ctl_s   dr_ctl;
	jtp_pkg::jtp_ctl_s   ir_ctl;
	logic                ce_m_r;
	logic                ce_s_r;
	logic [2:0]          tms_cnt_r;
	logic [3:0]          ir_sh_r;
	logic [3:0]          ir_r;
	logic                byp_r;
	logic [31:0]         id_sh_r;
	logic [BSR_W-1:0]    bsr_sh_r;
	logic [BSR_W-1:0]    bsr_upd_r;
	logic                core_sel_r;
	logic                drive_r;
	logic                tlr_r;
	logic                tdo_r;
	logic                tdo_oe_r;
	logic                tlr_m_r;
	logic                tlr_s_r;
	logic                tap_reset_r;
	logic                pin_tap_r;
	logic [BSR_W-1:0]    bsr_m_r;
	logic [BSR_W-1:0]    bsr_s_r;

	// Clock enable crosses into the test clock domain as a level
	wire en = ce_s_r;
	wire in_tlr = (state_r == jtp_pkg::TLR);
	// Chains default on the edge that enters test-logic-reset, not one edge later,
	// so a host that leaves reset at once still finds every chain at its default
	wire to_tlr = (state_nxt == jtp_pkg::TLR);

	// Chain actions follow the controller state alone
	assign dr_ctl.capture = (state_r == jtp_pkg::CAP_DR);
	assign dr_ctl.shift   = (state_r == jtp_pkg::SH_DR);
	assign dr_ctl.update  = (state_r == jtp_pkg::UPD_DR);
	assign ir_ctl.capture = (state_r == jtp_pkg::CAP_IR);
	assign ir_ctl.shift   = (state_r == jtp_pkg::SH_IR);
	assign ir_ctl.update  = (state_r == jtp_pkg::UPD_IR);

	// Data chain selection from the parallel instruction; all else is bypass
	wire sel_id   = (ir_r == jtp_pkg::IR_IDCODE);
	wire sel_bsr  = (ir_r == jtp_pkg::IR_SAMPLE);
	wire sel_core = (ir_r == jtp_pkg::IR_ABORT) || (ir_r == jtp_pkg::IR_DPACC) || (ir_r == jtp_pkg::IR_APACC);
	wire sel_byp  = !sel_id && !sel_bsr && !sel_core;

	// Decode of the code about to be loaded, so the selects come from flops
	wire nxt_core  = (ir_sh_r == jtp_pkg::IR_ABORT) || (ir_sh_r == jtp_pkg::IR_DPACC)
		|| (ir_sh_r == jtp_pkg::IR_APACC);
	wire nxt_drive = (ir_sh_r == jtp_pkg::IR_EXTEST) || (ir_sh_r == jtp_pkg::IR_INTEST);

	// Serial output candidate, chosen while shifting
	wire dr_out = sel_core ? I_CORE_TDO : sel_id ? id_sh_r[0] : sel_bsr ? bsr_sh_r[0] : byp_r;
	wire tdo_nxt = ir_ctl.shift ? ir_sh_r[0] : dr_out;
	wire oe_nxt  = ir_ctl.shift || dr_ctl.shift;

	// Standard TAP transition table
	always_comb begin
		case (state_r)
			jtp_pkg::TLR:    state_nxt = I_TMS ? jtp_pkg::TLR    : jtp_pkg::RTI;
			jtp_pkg::RTI:    state_nxt = I_TMS ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_DR: state_nxt = I_TMS ? jtp_pkg::SEL_IR : jtp_pkg::CAP_DR;
			jtp_pkg::CAP_DR: state_nxt = I_TMS ? jtp_pkg::EX1_DR : jtp_pkg::SH_DR;
			jtp_pkg::SH_DR:  state_nxt = I_TMS ? jtp_pkg::EX1_DR : jtp_pkg::SH_DR;
			jtp_pkg::EX1_DR: state_nxt = I_TMS ? jtp_pkg::UPD_DR : jtp_pkg::PAU_DR;
			jtp_pkg::PAU_DR: state_nxt = I_TMS ? jtp_pkg::EX2_DR : jtp_pkg::PAU_DR;
			jtp_pkg::EX2_DR: state_nxt = I_TMS ? jtp_pkg::UPD_DR : jtp_pkg::SH_DR;
			jtp_pkg::UPD_DR: state_nxt = I_TMS ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_IR: state_nxt = I_TMS ? jtp_pkg::TLR    : jtp_pkg::CAP_IR;
			jtp_pkg::CAP_IR: state_nxt = I_TMS ? jtp_pkg::EX1_IR : jtp_pkg::SH_IR;
			jtp_pkg::SH_IR:  state_nxt = I_TMS ? jtp_pkg::EX1_IR : jtp_pkg::SH_IR;
			jtp_pkg::EX1_IR: state_nxt = I_TMS ? jtp_pkg::UPD_IR : jtp_pkg::PAU_IR;
			jtp_pkg::PAU_IR: state_nxt = I_TMS ? jtp_pkg::EX2_IR : jtp_pkg::PAU_IR;
			jtp_pkg::EX2_IR: state_nxt = I_TMS ? jtp_pkg::UPD_IR : jtp_pkg::SH_IR;
			jtp_pkg::UPD_IR: state_nxt = I_TMS ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			default:         state_nxt = jtp_pkg::TLR;
		endcase
	end

	// Enable synchroniser; not gated itself so a frozen block still sees the release
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			ce_m_r <= 1'h0;
			ce_s_r <= 1'h0;
		end else begin
			ce_m_r <= I_CE;
			ce_s_r <= ce_m_r;
		end
	end

	// State register; power-on reset lands in test-logic-reset
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_r <= jtp_pkg::TLR;
		end else if (en) begin
			state_r <= state_nxt;
		end
	end

	// Count of consecutive TMS-high edges, saturating
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			tms_cnt_r <= 3'h0;
		end else if (en) begin
			tms_cnt_r <= !I_TMS ? 3'h0 : (tms_cnt_r == jtp_pkg::TMS_CNT_MAX) ? tms_cnt_r : tms_cnt_r + 3'h1;
		end
	end

	// Instruction chain: capture pattern, shift from TDI, update parallel
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			ir_sh_r    <= jtp_pkg::IR_CAPTURE;
			ir_r       <= jtp_pkg::IR_IDCODE;
			core_sel_r <= 1'h0;
			drive_r    <= 1'h0;
		end else if (en) begin
			if (to_tlr) begin
				ir_sh_r    <= jtp_pkg::IR_CAPTURE;
				ir_r       <= jtp_pkg::IR_IDCODE;
				core_sel_r <= 1'h0;
				drive_r    <= 1'h0;
			end else if (ir_ctl.capture) begin
				ir_sh_r <= jtp_pkg::IR_CAPTURE;
			end else if (ir_ctl.shift) begin
				ir_sh_r <= {I_TDI, ir_sh_r[3:1]};
			end else if (ir_ctl.update) begin
				ir_r       <= ir_sh_r;
				core_sel_r <= nxt_core;
				drive_r    <= nxt_drive;
			end
		end
	end

	// Bypass and identification chains
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			byp_r   <= 1'h0;
			id_sh_r <= IDCODE_VAL;
		end else if (en) begin
			if (to_tlr) begin
				byp_r   <= 1'h0;
				id_sh_r <= IDCODE_VAL;
			end else if (dr_ctl.capture) begin
				byp_r   <= 1'h0;
				id_sh_r <= sel_id ? IDCODE_VAL : id_sh_r;
			end else if (dr_ctl.shift) begin
				byp_r   <= sel_byp ? I_TDI : byp_r;
				id_sh_r <= sel_id ? {I_TDI, id_sh_r[31:1]} : id_sh_r;
			end
		end
	end

	// Pin levels are asynchronous to the test clock; two flops before capture
	// Limitation: a pin moving within two test clocks may be caught either side
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			bsr_m_r <= '0;
			bsr_s_r <= '0;
		end else if (en) begin
			bsr_m_r <= I_BSR_PINS;
			bsr_s_r <= bsr_m_r;
		end
	end

	// Boundary chain: only sample/preload and reset entry move it; EXTEST/INTEST use what it holds
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			bsr_sh_r  <= '0;
			bsr_upd_r <= '0;
		end else if (en) begin
			if (to_tlr) begin
				bsr_sh_r  <= '0;
				bsr_upd_r <= '0;
			end else if (sel_bsr && dr_ctl.capture) begin
				bsr_sh_r <= bsr_s_r;
			end else if (sel_bsr && dr_ctl.shift) begin
				bsr_sh_r <= {I_TDI, bsr_sh_r[BSR_W-1:1]};
			end else if (sel_bsr && dr_ctl.update) begin
				bsr_upd_r <= bsr_sh_r;
			end
		end
	end

	// Reset level for the system side, from a flop so the crossing sees no glitch
	always_ff @(posedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			tlr_r <= 1'h1;
		end else if (en) begin
			tlr_r <= (state_nxt == jtp_pkg::TLR);
		end
	end

	// Output on the falling edge so a downstream port samples a settled bit
	always_ff @(negedge I_TCK or negedge I_NRST) begin
		if (!I_NRST) begin
			tdo_r    <= 1'h0;
			tdo_oe_r <= 1'h0;
		end else if (en) begin
			tdo_r    <= tdo_nxt;
			tdo_oe_r <= oe_nxt;
		end
	end

	// System side: synchronised reset status and shared-pin function select
	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			tlr_m_r     <= 1'h1;
			tlr_s_r     <= 1'h1;
			tap_reset_r <= 1'h1;
			pin_tap_r   <= jtp_pkg::PIN_TAP_RST;
		end else if (I_CE) begin
			tlr_m_r     <= tlr_r;
			tlr_s_r     <= tlr_m_r;
			tap_reset_r <= tlr_s_r;
			pin_tap_r   <= !I_GPIO_SEL;
		end
	end

	assign O_TDO       = tdo_r;
	assign O_TDO_OE    = tdo_oe_r;
	assign O_CORE_SEL  = core_sel_r;
	assign O_BSR_UPD   = bsr_upd_r;
	assign O_BSR_DRIVE = drive_r;
	assign O_TAP_RESET = tap_reset_r;
	assign O_PIN_TAP   = pin_tap_r;

	// Checks on the test clock domain
	a_five_tms_reset: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(tms_cnt_r == jtp_pkg::TMS_CNT_MAX) |-> (state_r == jtp_pkg::TLR))
		else $error("five TMS-high edges did not reach reset state");
	a_tms_next_state: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && state_r == jtp_pkg::RTI && I_TMS) |=> (state_r == jtp_pkg::SEL_DR))
		else $error("idle with TMS high did not go to DR select");
	a_ir_shift_in: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && ir_ctl.shift) |=> (ir_sh_r[3] == $past(I_TDI)) && (ir_sh_r[2:0] == $past(ir_sh_r[3:1])))
		else $error("instruction chain did not shift TDI in");
	a_tlr_defaults: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && in_tlr) |=> (ir_r == jtp_pkg::IR_IDCODE) && (bsr_upd_r == '0) && !core_sel_r)
		else $error("reset state left chains not at default");
	a_frozen_clock: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		!en |=> $stable(state_r) && $stable(ir_r) && $stable(id_sh_r) && $stable(bsr_sh_r))
		else $error("state moved while enable was low");
	a_ir_update: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && ir_ctl.update) |=> (ir_r == $past(ir_sh_r)))
		else $error("instruction update did not copy the chain");
	a_core_select: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && ir_ctl.update && nxt_core) |=> O_CORE_SEL ##1 (O_CORE_SEL || $past(in_tlr) || $past(ir_ctl.update)))
		else $error("core debug code did not select core output");
	a_unused_bypass: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(ir_r == jtp_pkg::IR_UNUSED) |-> sel_byp)
		else $error("unimplemented code not decoded as bypass");
	a_id_capture: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && dr_ctl.capture && sel_id) |=> (id_sh_r == IDCODE_VAL))
		else $error("identification chain did not capture its value");
	a_extest_still: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && !to_tlr && (ir_r == jtp_pkg::IR_EXTEST || ir_r == jtp_pkg::IR_INTEST)) |=> $stable(bsr_sh_r)
		&& $stable(bsr_upd_r))
		else $error("boundary chain moved under EXTEST or INTEST");
	a_tdo_release: assert property (@(negedge I_TCK) disable iff (!I_NRST)
		(en && !oe_nxt) |=> !O_TDO_OE)
		else $error("TDO driven outside shift states");
	a_por_reset: assert property (@(posedge I_TCK)
		$rose(I_NRST) |-> (state_r == jtp_pkg::TLR))
		else $error("power-on reset did not leave reset state");

	// Chain and output checks around entry, capture, shift and update
	a_enter_tlr_reset: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && to_tlr) |=> (ir_r == jtp_pkg::IR_IDCODE) && !drive_r && !core_sel_r && (bsr_upd_r == '0) && !byp_r)
		else $error("entering reset state left chains not at default");
	a_bsr_capture: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && dr_ctl.capture && sel_bsr) |=> (bsr_sh_r == $past(bsr_s_r)))
		else $error("boundary chain did not capture pin levels");
	a_bsr_update: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && dr_ctl.update && sel_bsr) |=> (bsr_upd_r == $past(bsr_sh_r)))
		else $error("boundary update did not copy the chain");
	a_tdo_shift_oe: assert property (@(negedge I_TCK) disable iff (!I_NRST)
		(en && oe_nxt) |=> O_TDO_OE)
		else $error("TDO not driven while shifting");
	a_drive_flag: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && ir_ctl.update && nxt_drive) |=> O_BSR_DRIVE)
		else $error("drive code did not raise the drive flag");
	a_bypass_shift: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && dr_ctl.shift && sel_byp) |=> (byp_r == $past(I_TDI)))
		else $error("bypass bit did not take TDI");
	a_id_shift: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && dr_ctl.shift && sel_id) |=> (id_sh_r == {$past(I_TDI), $past(id_sh_r[31:1])}))
		else $error("identification chain did not shift TDI in");
	a_ir_capture: assert property (@(posedge I_TCK) disable iff (!I_NRST)
		(en && ir_ctl.capture) |=> (ir_sh_r == jtp_pkg::IR_CAPTURE))
		else $error("instruction chain did not capture its pattern");
	a_frozen_tdo: assert property (@(negedge I_TCK) disable iff (!I_NRST)
		!en |=> $stable(O_TDO) && $stable(O_TDO_OE))
		else $error("TDO moved while enable was low");
endmodule // jtp_tap

// ### dv/jtag_tap_shift_chains_tb.sv
// Self-checking bench for the test access port
`timescale 1ns/100ps
module jtag_tap_shift_chains_tb;
	localparam int unsigned BSR_W = 8;
	localparam logic [31:0] ID_VAL = 32'h0BAD_F00D; // Arbitrary identification value
	logic             clk, nrst, ce, gpio_sel, core_tdo, tck, tms, tdi, tdo, tdo_oe, tdo_w;
	logic             core_sel, bsr_drive, tap_reset, pin_tap;
	logic [BSR_W-1:0] bsr_pins, bsr_upd;
	logic [63:0]      q;
	int               miscompares = 0;
	int               n_tests = 0;
	int               cycles = 0;
	// Released data-out pin is pulled up, so a stale value can never pass
	assign tdo_w = tdo_oe ? tdo : 1'h1;
	jtp_tap #(.BSR_W(BSR_W), .IDCODE_VAL(ID_VAL)) u_jtp_tap (.I_SYS_CLK(clk), .I_NRST(nrst), .I_CE(ce),
		.I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .I_CORE_TDO(core_tdo), .I_BSR_PINS(bsr_pins),
		.I_GPIO_SEL(gpio_sel), .O_TDO(tdo), .O_TDO_OE(tdo_oe), .O_CORE_SEL(core_sel), .O_BSR_UPD(bsr_upd),
		.O_BSR_DRIVE(bsr_drive), .O_TAP_RESET(tap_reset), .O_PIN_TAP(pin_tap));
	jtp_host u_jtp_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_w));
	// System clock
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// Data out may only move just after a falling link edge
	always @(tdo or tdo_oe) if (nrst === 1'h1) chk(tck, 1'h0);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Wait edges, then step past them so registered outputs have settled
	task automatic sys(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic ir_load(input logic [3:0] c);
		u_jtp_host.scan(1'h1, 4, {60'h0, c}, q);
		chk(q, jtp_pkg::IR_CAPTURE);
	endtask
	// Power-on values, then identification chain selected straight out of reset
	task automatic t_power();
		chk({tap_reset, pin_tap, tdo_oe}, 3'h6);
		chk({core_sel, bsr_drive, bsr_upd}, '0);
		u_jtp_host.go_reset(7);
		sys(12);
		chk(tap_reset, 1'h0);
		u_jtp_host.scan(1'h0, 32, 64'h0, q);
		chk(q, ID_VAL);
		chk(tdo_oe, 1'h0);
	endtask
	// Pin sample then preload; the update must survive a long parked clock
	task automatic t_sample();
		@(posedge clk);
		bsr_pins <= 8'hA5;
		ir_load(jtp_pkg::IR_SAMPLE);
		u_jtp_host.scan(1'h0, BSR_W, 64'h3C, q);
		chk(q, 64'hA5);
		sys(400);
		chk(bsr_upd, 8'h3C);
	endtask
	// One-bit paths: bypass, an unused code, and the two drive codes
	task automatic t_ir();
		logic [3:0] c [4] = '{jtp_pkg::IR_BYPASS, jtp_pkg::IR_UNUSED, jtp_pkg::IR_EXTEST, jtp_pkg::IR_INTEST};
		foreach (c[i]) begin
			ir_load(c[i]);
			chk(bsr_drive, i >= 2);
			u_jtp_host.scan(1'h0, 2, 64'h1, q);
			chk(q, 64'h2);
			chk(bsr_upd, 8'h3C);
		end
	endtask
	// Core debug codes hand data out to the core line; device codes take it back
	task automatic t_core();
		logic [3:0] c [4] = '{jtp_pkg::IR_ABORT, jtp_pkg::IR_DPACC, jtp_pkg::IR_APACC, jtp_pkg::IR_BYPASS};
		@(posedge clk);
		core_tdo <= 1'h1;
		foreach (c[i]) begin
			ir_load(c[i]);
			chk(core_sel, i < 3);
			u_jtp_host.scan(1'h0, 3, 64'h0, q);
			chk(q, (i < 3) ? 64'h7 : 64'h0);
		end
	endtask
	// Four high edges from a shift state must not reset; the fifth must
	task automatic t_five();
		logic d;
		ir_load(jtp_pkg::IR_EXTEST);
		u_jtp_host.bit_io(1'h1, 1'h1, d);
		u_jtp_host.bit_io(1'h0, 1'h1, d);
		u_jtp_host.bit_io(1'h0, 1'h1, d);
		repeat (4) u_jtp_host.bit_io(1'h1, 1'h1, d);
		chk(bsr_drive, 1'h1);
		u_jtp_host.bit_io(1'h1, 1'h1, d);
		sys(12);
		chk({tap_reset, bsr_drive, bsr_upd}, 10'h200);
		u_jtp_host.bit_io(1'h0, 1'h1, d);
	endtask
	// Shared pins follow the function select one edge later
	task automatic t_gpio();
		@(posedge clk);
		gpio_sel <= 1'h1;
		sys(2);
		chk(pin_tap, 1'h0);
		gpio_sel <= 1'h0;
		sys(2);
		chk(pin_tap, 1'h1);
	endtask
	// Main sequence
	initial begin
		nrst = 1'h0;
		ce = 1'h0;
		gpio_sel = 1'h0;
		core_tdo = 1'h0;
		bsr_pins = '0;
		sys(6);
		nrst <= 1'h1;
		ce <= 1'h1;
		sys(2);
		t_power();
		t_sample();
		t_ir();
		t_core();
		t_five();
		t_gpio();
		end_sim();
	end
endmodule // jtag_tap_shift_chains_tb

// ### dv/jtp_host.sv
// Behavioural test host that clocks the link and walks the chains
`timescale 1ns/100ps
module jtp_host (
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi,
	input  wire logic i_tdo
);
	localparam real HALF = 62.5; // Half of the 125 ns link period
	// Clock parks high between frames; lines start at pull-up level, and TMS rests low after each frame
	initial begin
		o_tck = 1'h1;
		o_tms = 1'h1;
		o_tdi = 1'h1;
	end
	// One link cycle; lines move only after the falling edge so they are stable at the rise
	task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
		o_tck = 1'h0;
		o_tms = tms;
		o_tdi = tdi;
		#(HALF);
		tdo = i_tdo;
		o_tck = 1'h1;
		#(HALF);
	endtask
	// Mode select held high long enough to cover the enable sync, then idle
	task automatic go_reset(input int n);
		logic d;
		for (int i = 0; i < n; i++) bit_io(1'h1, 1'h1, d);
		bit_io(1'h0, 1'h1, d);
	endtask
	// Full scan from idle back to idle; bits go and come least significant first
	task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
		logic d;
		dout = '0;
		bit_io(1'h1, 1'h1, d);
		if (ir) bit_io(1'h1, 1'h1, d);
		bit_io(1'h0, 1'h1, d);
		bit_io(1'h0, 1'h1, d);
		for (int i = 0; i < n; i++) begin
			bit_io(i == n - 1, din[i], d);
			dout[i] = d;
		end
		bit_io(1'h1, 1'h1, d);
		bit_io(1'h0, 1'h1, d);
	endtask
endmodule // jtp_host
